// *** design/ulpi_link.sv ***
/*
 ULPI link controller: drives a ULPI PHY over its pins in synchronous mode,
 register write/read, suspend entry and stp wake-up.
 Assumes ulpiClk is the PHY's 60 MHz clock; user side runs on clk.
*/
// What this block does
// - Only one interface mode enabled at once
// - Pin outputs synchronised to ulpi clock; doneToggle, lineLevel and phyIrq to clk
// - Idle bus zero, transfers begin nonzero TXCMD
// - Bus ignored for turnaround after dir change
// - Stp one cycle after last byte
// - Stp during dir high aborts PHY transfer; this block raises stp with dir high to wake the PHY, or in S_DATA when nxt comes while dir is high
// - Stp held high wakes PHY to synchronous
// - Next byte presented the cycle after nxt
// - Suspend via clearing suspend bit, exit by stp
// - Clock must run before stp wake-up
`timescale 1ns/100ps
module ulpi_link
    import ulpi_link_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ulpiClk,
    input wire logic dir,
    input wire logic nxt,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic stp,
    input wire logic reqToggle,
    input wire logic [1:0] reqKind,
    input wire logic [5:0] reqAddr,
    input wire logic [7:0] reqData,
    output logic doneToggle,
    output logic [7:0] rdData,
    output logic [7:0] rxcmd,
    output logic [1:0] lineLevel,
    output logic phyIrq,
    output logic suspended
);
    // Request kinds: 0 write, 1 read, 2 suspend, 3 wake
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_CMD = 3'b001, S_DATA = 3'b011, S_STOP = 3'b010,
        S_TURN = 3'b110, S_RDWAIT = 3'b111, S_SUSP = 3'b101, S_WAKE = 3'b100
    } state_e;
    state_e state;
    logic [1:0] rstSync;
    logic ulpiRstN;
    logic [2:0] reqSync;
    logic reqPend, doneInt;
    logic dirQ, nxtQ;
    logic [7:0] dataQ;
    logic [7:0] wrByte;
    logic rdMode;
    logic [3:0] wakeCnt;
    logic [1:0] doneSync;

    // Reset released per domain through two flops
    always_ff @(posedge ulpiClk or negedge rst_n) begin
        if (!rst_n) rstSync <= 2'h0;
        else rstSync <= {rstSync[0], 1'b1};
    end
    assign ulpiRstN = rstSync[1];

    // Same two-flop release for the user clock domain
    logic [1:0] clkRstSync;
    logic clkRstN;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) clkRstSync <= 2'h0;
        else clkRstSync <= {clkRstSync[0], 1'b1};
    end
    assign clkRstN = clkRstSync[1];

    // Request toggle crosses from clk domain; reqSync[0] feeds only reqSync[1]
    always_ff @(posedge ulpiClk or negedge ulpiRstN) begin
        if (!ulpiRstN) reqSync <= 3'h0;
        else reqSync <= {reqSync[1:0], reqToggle};
    end
    assign reqPend = reqSync[2] ^ doneInt;

    // Pins registered on ulpiClk, which is their own clock
    always_ff @(posedge ulpiClk or negedge ulpiRstN) begin
        if (!ulpiRstN) begin
            dirQ <= 1'b1;
            nxtQ <= 1'b0;
            dataQ <= 8'h00;
        end else begin
            dirQ <= dir;
            nxtQ <= nxt;
            dataQ <= dataIn;
        end
    end

    // Main sequencer; every pin output is registered on the PHY clock
    always_ff @(posedge ulpiClk or negedge ulpiRstN) begin
        if (!ulpiRstN) begin
            state <= S_SUSP;
            dataOut <= BUS_IDLE;
            dataOe <= 1'b0;
            stp <= 1'b0;
            doneInt <= 1'b0;
            rdData <= 8'h00;
            rxcmd <= 8'h00;
            rdMode <= 1'b0;
            wrByte <= 8'h00;
            wakeCnt <= 4'h0;
            suspended <= 1'b0;
        end else begin
            stp <= 1'b0;
            // Capture RXCMD when dir held high without nxt, no turnaround
            if (dir && dirQ && !nxt && state != S_RDWAIT && !suspended)
                rxcmd <= dataIn;
            unique case (state)
                S_IDLE: begin
                    dataOe <= !dir;
                    dataOut <= BUS_IDLE;
                    if (dir) begin
                        dataOe <= 1'b0;
                    end else if (reqPend) begin
                        if (reqKind == 2'h3) begin
                            doneInt <= ~doneInt;
                        end else begin
                            rdMode <= (reqKind == 2'h1);
                            wrByte <= (reqKind == 2'h2) ? SUSPEND_ACTIVE_LOW_BIT : reqData;
                            dataOut <= (reqKind == 2'h1) ? {CMD_REGRD, reqAddr} :
                                // Only the suspend bit is ever cleared; no serial mode is set
                                (reqKind == 2'h2) ? {CMD_REGWR, ADDR_FUNC_CTRL_CLR}
                                                  : {CMD_REGWR, reqAddr};
                            suspended <= (reqKind == 2'h2);
                            state <= S_CMD;
                        end
                    end
                end
                S_CMD: begin
                    if (dir) begin
                        // PHY took the bus; retry later
                        dataOe <= 1'b0;
                        dataOut <= BUS_IDLE;
                        suspended <= 1'b0;
                        state <= S_IDLE;
                    end else if (nxt) begin
                        if (rdMode) begin
                            dataOe <= 1'b0;
                            dataOut <= BUS_IDLE;
                            state <= S_TURN;
                        end else begin
                            dataOut <= wrByte;
                            state <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    if (nxt) begin
                        dataOut <= BUS_IDLE;
                        stp <= 1'b1;
                        state <= S_STOP;
                    end
                end
                S_STOP: begin
                    doneInt <= ~doneInt;
                    // Suspend: PHY raises dir and holds it
                    state <= suspended ? S_SUSP : S_IDLE;
                    dataOe <= !suspended && !dir;
                end
                S_TURN: begin
                    if (dir) state <= S_RDWAIT;
                end
                S_RDWAIT: begin
                    rdData <= dataIn;
                    doneInt <= ~doneInt;
                    state <= S_IDLE;
                end
                S_SUSP: begin
                    dataOe <= 1'b0;
                    suspended <= 1'b1;
                    if (reqPend && reqKind == 2'h3) begin
                        // Caller guarantees crystal clock running first
                        stp <= 1'b1;
                        wakeCnt <= WAKE_HOLD;
                        state <= S_WAKE;
                    end else if (!dir && !dirQ) begin
                        // Power-up done, PHY in synchronous mode
                        suspended <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                S_WAKE: begin
                    stp <= dir;
                    if (!dir) begin
                        suspended <= 1'b0;
                        doneInt <= ~doneInt;
                        state <= S_IDLE;
                    end else if (wakeCnt != 4'h0) begin
                        wakeCnt <= wakeCnt - 4'h1;
                    end
                end
            endcase
        end
    end

    // Low-power status; bits are asynchronous so sampled twice
    logic [2:0] lpMeta, lpSync;
    always_ff @(posedge clk or negedge clkRstN) begin
        if (!clkRstN) begin
            lpMeta <= 3'h0;
            lpSync <= 3'h0;
            lineLevel <= 2'h0;
            phyIrq <= 1'b0;
        end else begin
            lpMeta <= {dataIn[LP_DATA_INT], dataIn[LP_LEVEL_BIT1], dataIn[LP_LEVEL_BIT0]};
            lpSync <= lpMeta;
            lineLevel <= lpSync[1:0];
            phyIrq <= lpSync[2];
        end
    end

    // Done toggle back to clk
    logic [2:0] doneMeta;
    always_ff @(posedge clk or negedge clkRstN) begin
        if (!clkRstN) begin
            doneMeta <= 3'h0;
            doneToggle <= 1'b0;
        end else begin
            doneMeta <= {doneMeta[1:0], doneInt};
            doneToggle <= doneMeta[2];
        end
    end

    chk_stp_pulse: assert property (@(posedge ulpiClk) disable iff (!ulpiRstN)
        (state == S_DATA && nxt) |=> stp ##1 !stp)
        else $error("stp not a single pulse after last byte");
    chk_no_drive_dir: assert property (@(posedge ulpiClk) disable iff (!ulpiRstN)
        (dirQ && $past(dirQ) && state != S_CMD && state != S_STOP) |-> !dataOe)
        else $error("link drives bus while dir high");
    chk_idle_zero: assert property (@(posedge ulpiClk) disable iff (!ulpiRstN)
        (state == S_IDLE && dataOe) |-> dataOut == BUS_IDLE)
        else $error("idle bus not zero");
    chk_wake_stp: assert property (@(posedge ulpiClk) disable iff (!ulpiRstN)
        (state == S_SUSP && reqPend && reqKind == 2'h3) |=> stp)
        else $error("wake stp missing");
    chk_txcmd_nonzero: assert property (@(posedge ulpiClk) disable iff (!ulpiRstN)
        (state == S_CMD && dataOe) |-> dataOut != BUS_IDLE)
        else $error("transmit command byte is zero");
    chk_release_on_dir: assert property (@(posedge ulpiClk) disable iff (!ulpiRstN)
        (dir && state != S_DATA) |=> !dataOe)
        else $error("link still drives bus after dir high");
    chk_stp_context: assert property (@(posedge ulpiClk) disable iff (!ulpiRstN)
        stp |-> (state == S_STOP || state == S_WAKE))
        else $error("stp outside stop or wake");
    cov_write: cover property (@(posedge ulpiClk) disable iff (!ulpiRstN) state == S_STOP);
    cov_read: cover property (@(posedge ulpiClk) disable iff (!ulpiRstN) state == S_RDWAIT);
    cov_wake: cover property (@(posedge ulpiClk) disable iff (!ulpiRstN) state == S_WAKE);
endmodule : ulpi_link

// *** design/ulpi_link_pkg.sv ***
/*
 Shared constants for the ULPI link-side controller.
 Assumes the PHY drives the 60 MHz interface clock and the direction line.
*/
package ulpi_link_pkg;
    localparam logic [7:0] BUS_IDLE = 8'h00;
    // Register write TXCMD: command bits 7:6 = 2'b10, address in 5:0
    localparam logic [1:0] CMD_REGWR = 2'h2;
    localparam logic [1:0] CMD_REGRD = 2'h3;
    localparam logic [5:0] ADDR_FUNC_CTRL_CLR = 6'h06;
    // Bit 6 of the function control register is the active-low suspend bit
    localparam logic [7:0] SUSPEND_ACTIVE_LOW_BIT = 8'h40;
    localparam int LP_DATA_INT = 3;
    localparam int LP_LEVEL_BIT0 = 0;
    localparam int LP_LEVEL_BIT1 = 1;
    // Start value of wakeCnt on wake; stp stays high until the PHY drops dir, whatever the count
    localparam logic [3:0] WAKE_HOLD = 4'h4;
endpackage : ulpi_link_pkg

// *** tb/ulpi_phy_model.sv ***
/*
 Behavioural ULPI PHY: register file, register write/read, suspend, stp wake.
 Assumes the link samples and drives on rising ulpiClk edges.
*/
`timescale 1ns/100ps
module ulpi_phy_model
    import ulpi_link_pkg::*;
(
    input wire logic ulpiClk,
    input wire logic rst_n,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic stp,
    input wire logic [1:0] line,
    input wire logic irq,
    output logic dir,
    output logic nxt,
    output logic [7:0] dataIn
);
    logic [7:0] regs [64];
    logic [7:0] cmd, wdat, phyBus;
    logic lp, rxFlag;
    int st;
    // Undriven bus shows the inverse, so a stale value never matches
    assign dataIn = lp ? {4'h0, irq, 1'b0, line}
        : dir ? phyBus : dataOe ? dataOut : ~dataOut;
    always @(posedge ulpiClk or negedge rst_n) begin
        if (!rst_n) begin
            dir <= 1'b1;
            nxt <= 1'b0;
            lp <= 1'b0;
            rxFlag <= 1'b0;
            st <= 11;
            phyBus <= 8'h00;
            foreach (regs[i]) regs[i] <= 8'h00;
            regs[6] <= SUSPEND_ACTIVE_LOW_BIT;
        end else begin
            // Turnaround cycles carry a changing pattern
            phyBus <= ~phyBus;
            case (st)
                0: if (dataOe && dataOut != 8'h00) begin
                    nxt <= 1'b1;
                    cmd <= dataOut;
                    st <= 1;
                end
                1: if (cmd[7:6] == CMD_REGWR) begin
                    st <= 2;
                end else begin
                    // Read byte is not receive data, so nxt stays low
                    nxt <= 1'b0;
                    dir <= 1'b1;
                    st <= 4;
                end
                2: begin
                    wdat <= dataOut;
                    nxt <= 1'b0;
                    st <= 3;
                end
                3: if (stp) begin
                    if (cmd[5:0] == ADDR_FUNC_CTRL_CLR) begin
                        regs[6] <= regs[6] & ~wdat;
                    end else begin
                        regs[cmd[5:0]] <= wdat;
                    end
                    lp <= cmd[5:0] == ADDR_FUNC_CTRL_CLR && (wdat & SUSPEND_ACTIVE_LOW_BIT) != 0;
                    dir <= cmd[5:0] == ADDR_FUNC_CTRL_CLR;
                    st <= cmd[5:0] == ADDR_FUNC_CTRL_CLR ? 7 : 0;
                end
                4: begin
                    phyBus <= rxFlag ? {6'h07, line} : regs[cmd[5:0]];
                    st <= 5;
                end
                5: begin
                    dir <= 1'b0;
                    rxFlag <= 1'b0;
                    st <= 0;
                end
                7: if (stp) begin
                    lp <= 1'b0;
                    dir <= 1'b0;
                    rxFlag <= irq;
                    st <= irq ? 10 : 0;
                end
                10: if (!stp) begin
                    dir <= 1'b1;
                    st <= 4;
                end
                default: begin
                    dir <= 1'b0;
                    st <= 0;
                end
            endcase
        end
    end
endmodule : ulpi_phy_model

// *** tb/tb.sv ***
/*
 Self-checking bench for ulpi_link against the PHY model.
 Assumes the design's CONTRACT: one toggle request outstanding at a time.
*/
`timescale 1ns/100ps
module tb;
    typedef struct {logic [1:0] kind; logic [5:0] addr; logic [7:0] val;} note_s;
    logic clk = 0, ulpiClk = 0, rst_n = 0, reqToggle = 0, irq = 0, lastDone = 0;
    logic [1:0] reqKind = 0, line = 0, lineLevel;
    logic [5:0] reqAddr = 0;
    logic [7:0] reqData = 0, dataIn, dataOut, rdData, rxcmd;
    logic dir, nxt, dataOe, stp, doneToggle, phyIrq, suspended;
    logic [31:0] seed = 32'hb5565d3e;
    int failures = 0, n_compared = 0, cycles = 0;
    note_s notes[$];
    always #2 clk = ~clk;
    // Offset start keeps the link clock out of phase with clk
    initial begin
        #1.3;
        forever #24 ulpiClk = ~ulpiClk;
    end
    ulpi_link i_ulpi_link (.clk(clk), .rst_n(rst_n), .ulpiClk(ulpiClk), .dir(dir), .nxt(nxt),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .stp(stp), .reqToggle(reqToggle),
        .reqKind(reqKind), .reqAddr(reqAddr), .reqData(reqData), .doneToggle(doneToggle),
        .rdData(rdData), .rxcmd(rxcmd), .lineLevel(lineLevel), .phyIrq(phyIrq),
        .suspended(suspended));
    ulpi_phy_model i_ulpi_phy_model (.ulpiClk(ulpiClk), .rst_n(rst_n), .dataOut(dataOut),
        .dataOe(dataOe), .stp(stp), .line(line), .irq(irq), .dir(dir), .nxt(nxt), .dataIn(dataIn));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic req(input logic [1:0] k, input logic [5:0] a, input logic [7:0] d,
            input logic [7:0] e);
        int n;
        notes.push_back('{k, a, e});
        @(posedge clk);
        reqKind <= k;
        reqAddr <= a;
        reqData <= d;
        reqToggle <= ~reqToggle;
        @(posedge clk);
        n = 0;
        while (doneToggle !== reqToggle && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n == 3000) failures++;
    endtask : req
    always @(posedge clk) begin
        note_s n;
        cycles++;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
        if (rst_n && doneToggle !== lastDone) begin
            lastDone = doneToggle;
            n = notes.pop_front();
            case (n.kind)
                2'd0: check("written reg", i_ulpi_phy_model.regs[n.addr], n.val);
                2'd1: check("rdData", rdData, n.val);
                default: check("suspended", {7'h0, suspended}, n.val);
            endcase
        end
    end
    initial begin
        logic [31:0] r;
        logic [5:0] a;
        logic [7:0] d;
        int n;
        repeat (3) @(posedge ulpiClk);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ulpiClk);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            a = {2'b01, r[3:0]};
            d = r[15:8] | 8'h01;
            req(2'd0, a, d, d);
            req(2'd1, a, 8'h00, d);
        end
        $display("test write and read-back ended");
        // Wake while already awake completes at once, stays out of suspend
        req(2'd3, 6'h00, 8'h00, 8'h00);
        req(2'd2, 6'h00, 8'h00, 8'h01);
        repeat (4) begin
            r = rnd();
            @(posedge clk);
            line <= r[1:0];
            irq <= r[2];
            repeat (12) @(posedge clk);
            check("lineLevel", {6'h0, lineLevel}, {6'h0, line});
            check("phyIrq", {7'h0, phyIrq}, {7'h0, irq});
        end
        $display("test suspend line state ended");
        @(posedge clk);
        irq <= 1'b1;
        line <= 2'b10;
        repeat (12) @(posedge clk);
        req(2'd3, 6'h00, 8'h00, 8'h00);
        n = 0;
        while (rxcmd !== 8'h1e && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("rxcmd", rxcmd, {6'h07, 2'b10});
        req(2'd1, a, 8'h00, d);
        $display("test wake ended");
        test_done();
    end
endmodule : tb
